// ---- rtl/video_cfg_defs.vh ----
// constants for the video configuration register and its decode
// assumes inclusion by bare name from the design files
`ifndef VIDEO_CFG_DEFS_VH
`define VIDEO_CFG_DEFS_VH
// field positions within the configuration word
`define KIND_HI        30
`define KIND_LO        29
`define DEPTH_BIT      28
`define BCAST_CLR_BIT  27
`define BASE_CLR_BIT   26
`define AUD_HI         25
`define AUD_LO         23
`define BANK_HI        11
`define BANK_LO        9
`define MASK_HI        7
`define MASK_LO        0
// output kind encodings
`define KIND_OFF       2'h0
`define KIND_VGA       2'h1
`define KIND_COMP1     2'h2
`define KIND_COMP2     2'h3
// reset value of the configuration word
`define CFG_RESET      32'h00000000
// frame geometry
`define PIX_ONE_BIT    6'h20
`define PIX_TWO_BIT    6'h10
// fifo geometry
`define FIFO_DEPTH     16
`define FIFO_AW        4
`endif

// ---- rtl/frame_fifo.v ----
// frame word fifo with valid/ready on both sides
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ns
module frame_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             ref_clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // word storage
  reg [AW:0]      wr_reg;          // write pointer with wrap bit
  reg [AW:0]      rd_reg;          // read pointer with wrap bit
  reg             oreg_valid;      // output register holds a word
  wire full  = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire empty = (wr_reg == rd_reg);
  wire push  = in_valid && !full;
  // refill the output register whenever it is empty or being taken
  wire pop   = !empty && (!oreg_valid || out_ready);
  assign in_ready  = !full;
  assign out_valid = oreg_valid;
  // storage write and registered read
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
    if (pop) begin
      out_data <= mem[rd_reg[AW-1:0]];
    end
  end
  // pointers and output flag
  always @(posedge ref_clk) begin
    if (reset) begin
      wr_reg     <= {(AW+1){1'b0}};
      rd_reg     <= {(AW+1){1'b0}};
      oreg_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      if (pop) begin
        oreg_valid <= 1'b1;
      end else if (out_ready) begin
        oreg_valid <= 1'b0;
      end
    end
  end
endmodule // frame_fifo

// ---- rtl/pixel_unpack.v ----
// splits a frame word into pixels of one or two bits
// assumes frames arrive with valid/ready and a fixed depth per frame
`timescale 1ns/1ns
`include "video_cfg_defs.vh"
module pixel_unpack (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire        two_bit,
  input  wire [31:0] frame_data,
  input  wire        frame_valid,
  output wire        frame_ready,
  input  wire        pix_take,
  output reg  [1:0]  pix_color,
  output reg         pix_valid
);
  reg [31:0] shift_reg; // remaining pixels, low end first
  reg [5:0]  left_reg;  // pixels left in the frame
  reg        mode_reg;  // depth latched with the frame
  wire last = (left_reg == 6'h01) && pix_take;
  assign frame_ready = (left_reg == 6'h00) || last;
  // load frames and shift out one pixel per take
  always @(posedge ref_clk) begin
    if (reset) begin
      shift_reg <= 32'h00000000;
      left_reg  <= 6'h00;
      mode_reg  <= 1'b0;
      pix_color <= 2'h0;
      pix_valid <= 1'b0;
    end else if (frame_ready && frame_valid) begin
      // depth is sampled per frame so a change never splits a word
      shift_reg <= frame_data;
      mode_reg  <= two_bit;
      left_reg  <= two_bit ? `PIX_TWO_BIT : `PIX_ONE_BIT;
      pix_valid <= 1'b1;
      pix_color <= two_bit ? frame_data[1:0] : {1'b0, frame_data[0]};
    end else if (pix_take && left_reg != 6'h00) begin
      left_reg  <= left_reg - 6'h01;
      // one-bit pixels only ever reach colors 0 and 1
      shift_reg <= mode_reg ? {2'h0, shift_reg[31:2]} : {1'b0, shift_reg[31:1]};
      pix_color <= mode_reg ? shift_reg[3:2] : {1'b0, shift_reg[1]};
      pix_valid <= (left_reg != 6'h01);
    end
  end
endmodule // pixel_unpack

// ---- rtl/video_output_config_decode.v ----
// per-core video configuration register, frame path and pin routing
// assumes the core reads and writes the register on the core clock
// and that color table entries arrive already expanded to 8-bit pin values
`timescale 1ns/1ns
`include "video_cfg_defs.vh"
module video_output_config_decode (
  input  wire        ref_clk,
  input  wire        reset,
  // register access from the owning core
  input  wire        cfg_write,
  input  wire [31:0] cfg_wdata,
  output reg  [31:0] cfg_rdata,
  // frame words from the wait-for-video feed
  input  wire [31:0] wait_video_feed,
  input  wire        feed_valid,
  output wire        feed_ready,
  // pixel clock tick from the scale logic
  input  wire        pixel_tick,
  // four color entries, one byte each
  input  wire [31:0] color_table,
  // first pll outputs of all eight cores
  input  wire [7:0]  core_pll_first,
  // aural carrier chosen for this generator
  output reg         aural_carrier,
  // shaped chroma/luma parts selected by this core
  output reg         broadcast_chroma_on,
  output reg         baseband_chroma_on,
  // 32 general pins
  output reg  [31:0] video_pins_out,
  output reg  [31:0] video_pins_drive
);
  // stored configuration word, reserved bits included
  reg  [31:0] video_configuration_reg;
  // pipeline of decoded pixel
  wire [1:0]  pix_color;
  wire        pix_valid;
  wire [31:0] fifo_data;
  wire        fifo_valid;
  wire        fifo_ready;
  // field extraction
  wire [1:0]  output_kind_field      = video_configuration_reg[`KIND_HI:`KIND_LO];
  wire        color_depth_bit        = video_configuration_reg[`DEPTH_BIT];
  wire        broadcast_color_enable = video_configuration_reg[`BCAST_CLR_BIT];
  wire        baseband_color_enable  = video_configuration_reg[`BASE_CLR_BIT];
  wire [2:0]  audio_carrier_source   = video_configuration_reg[`AUD_HI:`AUD_LO];
  wire [2:0]  pin_bank_select        = video_configuration_reg[`BANK_HI:`BANK_LO];
  wire [7:0]  pin_drive_mask         = video_configuration_reg[`MASK_HI:`MASK_LO];

  // register write and readback; instantiated once per core
  always @(posedge ref_clk) begin
    if (reset) begin
      video_configuration_reg <= `CFG_RESET;
      cfg_rdata               <= `CFG_RESET;
    end else begin
      if (cfg_write) begin
        video_configuration_reg <= cfg_wdata;
        cfg_rdata               <= cfg_wdata;
      end else begin
        cfg_rdata <= video_configuration_reg;
      end
    end
  end

  // frame words queue here; a full queue stalls the feed
  frame_fifo #(
    .WIDTH (32),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_data   (wait_video_feed),
    .in_valid  (feed_valid),
    .in_ready  (feed_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready)
  );

  // frame word to pixel colors by depth
  pixel_unpack u_unpack (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .two_bit     (color_depth_bit),
    .frame_data  (fifo_data),
    .frame_valid (fifo_valid),
    .frame_ready (fifo_ready),
    .pix_take    (pixel_tick),
    .pix_color   (pix_color),
    .pix_valid   (pix_valid)
  );

  // color entry lookup and lane arrangement
  reg [7:0] color_byte; // selected table entry
  reg [7:0] lane_val;   // value for the eight group pins
  reg       active;     // video is being generated
  always @* begin
    case (pix_color)
      2'h0:    color_byte = color_table[7:0];
      2'h1:    color_byte = color_table[15:8];
      2'h2:    color_byte = color_table[23:16];
      2'h3:    color_byte = color_table[31:24];
      default: color_byte = 8'h00;
    endcase
    active   = 1'b1;
    lane_val = 8'h00;
    case (output_kind_field)
      `KIND_OFF: begin
        active = 1'b0;
      end
      `KIND_VGA: begin
        lane_val = color_byte;
      end
      `KIND_COMP1: begin
        // broadcast nibble high, baseband nibble low
        lane_val = {color_byte[7:4], color_byte[3:0]};
      end
      `KIND_COMP2: begin
        // halves swapped relative to the first arrangement
        lane_val = {color_byte[3:0], color_byte[7:4]};
      end
      default: begin
        active = 1'b0;
      end
    endcase
    if (!pix_valid) begin
      lane_val = 8'h00;
    end
  end

  // reserved bank codes map to no pins; software must avoid them
  wire bank_ok = (pin_bank_select[2] == 1'b0);

  // pin routing, each pin of the bank gated by its mask bit
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : pin_route
      wire in_bank = bank_ok && (pin_bank_select[1:0] == g / 8);
      wire mask_on = pin_drive_mask[g % 8];
      always @(posedge ref_clk) begin
        if (reset) begin
          video_pins_out[g]   <= 1'b0;
          video_pins_drive[g] <= 1'b0;
        end else begin
          video_pins_out[g]   <= active && in_bank && mask_on && lane_val[g % 8];
          video_pins_drive[g] <= active && in_bank && mask_on;
        end
      end
    end
  endgenerate

  // chroma gates and aural carrier pick
  always @(posedge ref_clk) begin
    if (reset) begin
      broadcast_chroma_on <= 1'b0;
      baseband_chroma_on  <= 1'b0;
      aural_carrier       <= 1'b0;
    end else begin
      // chroma only matters in the composite arrangements
      broadcast_chroma_on <= output_kind_field[1] && broadcast_color_enable;
      baseband_chroma_on  <= output_kind_field[1] && baseband_color_enable;
      aural_carrier       <= core_pll_first[audio_carrier_source];
    end
  end
endmodule // video_output_config_decode

// ---- verif/video_sink.sv ----
// far side: eight core plls and the pin load network
// assumes one clock; a released pin is pulled to ground
`timescale 1ns/1ns
module video_sink (
  input  logic        ref_clk,
  input  logic [31:0] pins_out,
  input  logic [31:0] pins_drive,
  output logic [7:0]  pll,
  output logic [31:0] level
);
  // pll n runs at half the rate of pll n-1; free-running, no reset
  logic [7:0] pll_cnt = 8'h00; // one counter, one driver for every pll bit
  always @(posedge ref_clk) begin
    pll_cnt <= pll_cnt + 8'h01;
  end
  assign pll = pll_cnt;
  // only driven pins show a value, the rest sit at ground
  assign level = pins_out & pins_drive;
endmodule // video_sink

// ---- verif/vocd_asserts.sv ----
// checker for register and pin decode of the video block
// assumes a bind onto video_output_config_decode ports
`timescale 1ns/1ns
module vocd_asserts (
  input logic        ref_clk,
  input logic        reset,
  input logic        cfg_write,
  input logic [31:0] cfg_wdata,
  input logic [31:0] cfg_rdata,
  input logic [7:0]  core_pll_first,
  input logic        aural_carrier,
  input logic        broadcast_chroma_on,
  input logic        baseband_chroma_on,
  input logic [31:0] video_pins_drive
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire [1:0]  kind = cfg_rdata[30:29];             // output kind
  wire [2:0]  bank = cfg_rdata[11:9];              // pin bank
  wire        pick = core_pll_first[cfg_rdata[25:23]]; // chosen pll
  wire [31:0] want = (kind == 2'h0 || bank[2]) ? 32'h00000000 :
                     {24'h000000, cfg_rdata[7:0]} << {bank[1:0], 3'h0};
  // config steady over one edge, so the decode has caught up
  sequence held_s;
    cfg_rdata == $past(cfg_rdata) && !$past(reset);
  endsequence
  sequence wr_s;
    cfg_write;
  endsequence
  AST_OFF: assert property (held_s ##0 kind == 2'h0 |-> video_pins_drive == 32'h0)
    else $error("pins driven while video off");
  AST_BANK_RSV: assert property (held_s ##0 bank[2] |-> video_pins_drive == 32'h0)
    else $error("pins driven on reserved bank");
  AST_DRIVE_MAP: assert property (held_s |-> video_pins_drive == want)
    else $error("pin drive map wrong");
  AST_BCAST_CLR: assert property (held_s |-> broadcast_chroma_on == (kind[1] & cfg_rdata[27]))
    else $error("broadcast chroma wrong");
  AST_BASE_CLR: assert property (held_s |-> baseband_chroma_on == (kind[1] & cfg_rdata[26]))
    else $error("baseband chroma wrong");
  AST_AURAL: assert property (!$past(reset) |-> aural_carrier == $past(pick))
    else $error("aural carrier source wrong");
  AST_READBACK: assert property (wr_s |=> cfg_rdata == $past(cfg_wdata))
    else $error("config readback wrong");
  AST_KEEP: assert property (!cfg_write |=> $stable(cfg_rdata))
    else $error("config changed without write");
endmodule // vocd_asserts
bind video_output_config_decode vocd_asserts u_chk (.ref_clk, .reset, .cfg_write, .cfg_wdata,
  .cfg_rdata, .core_pll_first, .aural_carrier, .broadcast_chroma_on, .baseband_chroma_on,
  .video_pins_drive);

// ---- verif/tb.sv ----
// self-checking bench for the video configuration block
// assumes video_sink as far side and the bound checker
`timescale 1ns/1ns
module tb;
  logic        ref_clk = 0;             // 250 MHz core clock
  logic        reset = 1;               // sync reset
  logic        cfg_write = 0;           // register write strobe
  logic [31:0] cfg_wdata = 0;           // register write data
  logic [31:0] feed = 0;                // frame word
  logic        feed_valid = 0;          // frame offered
  logic        pixel_tick = 0;          // pixel advance
  logic [31:0] colors = 32'h96C33C5A;   // color entries 3..0
  wire  [31:0] cfg_rdata, pins_out, pins_drive, level;
  wire  [7:0]  pll;
  wire         feed_ready, aural, bc_on, bb_on;
  int          error_cnt = 0;           // mismatches
  int          total_checks = 0;        // comparisons
  always #2 ref_clk = ~ref_clk;
  video_output_config_decode dut (.ref_clk, .reset, .cfg_write, .cfg_wdata, .cfg_rdata,
    .wait_video_feed(feed), .feed_valid, .feed_ready, .pixel_tick, .color_table(colors),
    .core_pll_first(pll), .aural_carrier(aural), .broadcast_chroma_on(bc_on),
    .baseband_chroma_on(bb_on), .video_pins_out(pins_out), .video_pins_drive(pins_drive));
  video_sink sink (.ref_clk, .pins_out, .pins_drive, .pll, .level);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // wait n edges, then let their updates land
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task do_reset;
    @(posedge ref_clk) reset <= 1;
    repeat (8) @(posedge ref_clk);
    reset <= 0;
  endtask
  task wr(input logic [31:0] d);
    @(posedge ref_clk);
    cfg_write <= 1;
    cfg_wdata <= d;
    @(posedge ref_clk);
    cfg_write <= 0;
    cyc(2);
  endtask
  // reset value, then reserved bits only: stored, no pins driven
  task t_regs;
    chk(cfg_rdata, 32'h00000000);
    wr(32'h807FF100);
    chk(cfg_rdata, 32'h807FF100);
    chk(pins_drive, 32'h00000000);
  endtask
  // every kind across banks, masks and chroma enables
  task t_route;
    logic [31:0] e;
    logic [7:0]  m;
    for (int k = 0; k < 4; k++) begin
      for (int b = 0; b < 5; b++) begin
        m = (b == 0 || b == 4) ? 8'hFF : (b[0] ? 8'h0F : 8'hF0);
        e = (k == 0 || b > 3) ? 32'h0 : {24'h0, m} << (8 * b);
        wr({1'b0, k[1:0], 1'b0, b[1:0], 3'h0, 11'h0, b[2:0], 1'b0, m});
        chk(pins_drive, e);
        chk({bc_on, bb_on}, {k[1] & b[1], k[1] & b[0]});
      end
    end
  endtask
  // each audio source picks its own pll
  task t_aural;
    logic p;
    for (int s = 0; s < 8; s++) begin
      wr({6'h0, s[2:0], 23'h0});
      p = pll[s];
      cyc(1);
      chk(aural, p);
    end
  endtask
  // one frame word, first two pixels on bank 0
  task t_frame(input logic [1:0] k, input logic d, input logic [7:0] e0, input logic [7:0] e1);
    do_reset;
    wr({1'b0, k, d, 28'h00000FF});
    @(posedge ref_clk);
    feed <= 32'h0000000E;
    feed_valid <= 1;
    @(posedge ref_clk);
    feed_valid <= 0;
    cyc(6);
    chk(level[7:0], e0);
    @(posedge ref_clk);
    pixel_tick <= 1;
    @(posedge ref_clk);
    pixel_tick <= 0;
    cyc(4);
    chk(level[7:0], e1);
  endtask
  // fill with pixels stalled, then drain until accepting again
  task t_fill;
    int n;
    n = 0;
    do_reset;
    @(posedge ref_clk);
    feed_valid <= 1;
    repeat (40) begin
      #1;
      if (feed_ready !== 1'b1) break;
      n++;
      @(posedge ref_clk);
    end
    @(posedge ref_clk);
    feed_valid <= 0;
    chk(n >= 16 && n <= 18, 1);
    pixel_tick <= 1;
    cyc(700);
    chk(feed_ready, 1);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // about 1000 cycles of work; allow several times that
  initial begin
    #40000;
    error_cnt++;
    stop_test;
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 0;
    cyc(1);
    t_regs;
    t_route;
    t_aural;
    t_frame(2'h1, 1'b0, 8'h5A, 8'h3C);
    t_frame(2'h1, 1'b1, 8'hC3, 8'h96);
    t_frame(2'h2, 1'b1, 8'hC3, 8'h96);
    t_frame(2'h3, 1'b0, 8'hA5, 8'hC3);
    t_fill;
    stop_test;
  end
endmodule // tb
